// [inc/sar_conv_pkg.sv]
// Constants shared by the conversion sequencer and its serial shifter.
// Assumes a 10 MHz system clock; all times are in ns and become cycle counts here.
// Overview of operation
// - Busy stays within mode conversion limit.
// - Parallel result valid within conversion limit.
// - Result valid before busy falls, one cycle.
// - Read-during-convert frame starts after mode delay.
// - Read-after-convert frame starts at conversion end.
// - Busy falls just after frame marker falls.
// - Divider code sets minimum serial clock period.
// - First serial edge waits after frame start.
// - Frame marker waits after last serial edge.
// - High-rate read-after-convert busy kept short; busy covers the frame, within RAC_BUSY_MAX_NS for divider code 3 only.
// - Normal read-after-convert busy kept short; busy covers the frame, within RAC_BUSY_MAX_NS for divider code 3 only.
// - Low-power read-after-convert busy kept short; busy covers the frame, within RAC_BUSY_MAX_NS for divider code 3 only.
// - Serial clock floats after chip select rises.
// - Serial clock driven after chip select falls.
// - Slave output updates after external clock edge.
// - Byte order input swaps byte lanes in 8-bit parallel mode only.
`default_nettype none
package sar_conv_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 8;
  localparam logic [1:0] PORT_PAR16 = 2'h0;
  localparam logic [1:0] PORT_PAR8 = 2'h1;
  localparam logic [1:0] PORT_MASTER = 2'h2;
  localparam logic [1:0] PORT_SLAVE = 2'h3;
  localparam logic [4:0] PINS_RESET = 5'h03;
  localparam int PIN_CNV = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_ESCLK = 2;
  localparam int PIN_CHAIN = 3;
  localparam int START_SPACING_NS [3] = '{1000, 1250, 1500};
  localparam int CONV_MAX_NS [3] = '{750, 1000, 1250};
  localparam int RDC_SYNC_NS [3] = '{25, 275, 525};
  localparam int DATA_LEAD_NS = 45;
  localparam int SYNC_TO_BUSY_NS = 25;
  localparam int FIRST_EDGE_NS [4] = '{3, 17, 17, 17};
  localparam int SCLK_MIN_NS [4] = '{25, 50, 100, 200};
  localparam int SCLK_MAX_NS [4] = '{40, 70, 140, 280};
  localparam int TRAIL_NS [4] = '{3, 60, 140, 300};
  localparam int RAC_BUSY_MAX_NS [3][4] = '{'{1500, 2000, 3000, 5250},
                                            '{1750, 2250, 3250, 5550},
                                            '{2000, 2500, 3500, 5750}};
  localparam int SERIAL_HALF_EDGES = 2 * WORD_BITS;

  // Least time: round up, at least one cycle
  function automatic logic [CNT_W-1:0] cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1)
      c = 1;
    return CNT_W'(c);
  endfunction : cyc_min

  // Longest time: round down, at least one cycle
  function automatic logic [CNT_W-1:0] cyc_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    if (c < 1)
      c = 1;
    return CNT_W'(c);
  endfunction : cyc_max
endpackage : sar_conv_pkg
`default_nettype wire

// [inc/sar_shift_if.sv]
// Carrier between the conversion sequencer and the serial shifter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface sar_shift_if;
  logic start;
  logic slave_load;
  logic slave_edge;
  logic chain_bit;
  logic [1:0] div;
  logic [15:0] word;
  logic done;
  logic sclk;
  logic sync;
  logic sdo;
  modport ctrl (output start, slave_load, slave_edge, chain_bit, div, word,
                input done, sclk, sync, sdo);
  modport shifter (input start, slave_load, slave_edge, chain_bit, div, word,
                   output done, sclk, sync, sdo);
endinterface : sar_shift_if
`default_nettype wire

// [src/sar_conv_ctrl.sv]
// Conversion sequencer: start/busy handshake, parallel result and serial modes.
// Assumes a 10 MHz clock; start, chip select, external clock and chain input are pins.
`timescale 1ns/100ps
`default_nettype none
module sar_conv_ctrl (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic conversion_start_n_i,
  input wire logic cs_n_i,
  input wire logic ext_sclk_i,
  input wire logic chain_serial_in_i,
  input wire logic [1:0] throughput_mode_i,
  input wire logic [1:0] port_mode_i,
  input wire logic read_after_i,
  input wire logic [1:0] serial_clock_divider_i,
  input wire logic byte_order_select_i,
  input wire logic [15:0] sample_i,
  output logic busy_o,
  output logic [15:0] parallel_data_o,
  output logic sync_o,
  output logic sync_oe_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic serial_result_out_o,
  output logic serial_result_out_oe_o
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_CONV = 2'h1, ST_RESULT = 2'h3, ST_XFER = 2'h2} conv_state_t;
  localparam int CW = sar_conv_pkg::CNT_W;

  sar_shift_if sh ();

  conv_state_t state;
  conv_state_t next_state;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic cnv_d;
  logic esclk_d;
  logic [CW-1:0] cnt;
  logic [15:0] result;
  logic sh_start;
  logic slave_load;
  logic [CW-1:0] busy_len;

  // Pins pass two flip-flops; edges compare the second against its delayed copy
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_meta <= sar_conv_pkg::PINS_RESET;
      pin_sync <= sar_conv_pkg::PINS_RESET;
      cnv_d <= 1'b1;
      esclk_d <= 1'b0;
    end
    else
    begin
      pin_meta <= {1'b0, chain_serial_in_i, ext_sclk_i, cs_n_i, conversion_start_n_i};
      pin_sync <= pin_meta;
      cnv_d <= pin_sync[sar_conv_pkg::PIN_CNV];
      esclk_d <= pin_sync[sar_conv_pkg::PIN_ESCLK];
    end
  end

  wire start_edge = cnv_d & ~pin_sync[sar_conv_pkg::PIN_CNV];
  wire esclk_edge = ~esclk_d & pin_sync[sar_conv_pkg::PIN_ESCLK];
  wire cs_active = ~pin_sync[sar_conv_pkg::PIN_CS];

  wire [1:0] tp_idx = (throughput_mode_i == 2'h3) ? 2'h2 : throughput_mode_i;
  wire is_master = (port_mode_i == sar_conv_pkg::PORT_MASTER);
  wire is_slave = (port_mode_i == sar_conv_pkg::PORT_SLAVE);
  wire is_par = ~port_mode_i[1];
  wire rac = is_master & read_after_i;
  wire rdc = is_master & ~read_after_i;
  wire [CW-1:0] conv_cyc = sar_conv_pkg::cyc_max(sar_conv_pkg::CONV_MAX_NS[tp_idx]);
  wire [CW-1:0] rdc_cyc = sar_conv_pkg::cyc_max(sar_conv_pkg::RDC_SYNC_NS[tp_idx]);
  wire conv_last = (state == ST_CONV) && (cnt == conv_cyc - 2'h2);
  wire swap_bytes = (port_mode_i == sar_conv_pkg::PORT_PAR8) && byte_order_select_i;
  wire [15:0] lane_data = swap_bytes ? {sample_i[7:0], sample_i[15:8]} : sample_i;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start_edge)
          next_state = ST_CONV;
      ST_CONV:
        if (conv_last)
          next_state = ST_RESULT;
      ST_RESULT:
        next_state = rac ? ST_XFER : ST_IDLE;
      ST_XFER:
        if (sh.done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      busy_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= (next_state != state) ? '0 : cnt + 1'b1;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // Result and parallel lanes are valid one cycle before busy falls
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      result <= '0;
      parallel_data_o <= '0;
    end
    else if (conv_last)
    begin
      result <= sample_i;
      parallel_data_o <= lane_data;
    end
  end

  // Frame starts: mid-conversion with the previous word, or after it with the new one
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sh_start <= 1'b0;
      slave_load <= 1'b0;
    end
    else
    begin
      sh_start <= (rdc && state == ST_CONV && cnt == rdc_cyc - 1'b1)
                  || (rac && state == ST_RESULT);
      slave_load <= is_slave && conv_last;
    end
  end

  // Output enables follow the synchronised chip select
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sclk_oe_o <= 1'b0;
      sync_oe_o <= 1'b0;
      serial_result_out_oe_o <= 1'b0;
    end
    else
    begin
      sclk_oe_o <= is_master && cs_active;
      sync_oe_o <= is_master && cs_active;
      serial_result_out_oe_o <= (is_master || is_slave) && cs_active;
    end
  end

  assign sh.start = sh_start;
  assign sh.slave_load = slave_load;
  assign sh.slave_edge = is_slave && esclk_edge;
  assign sh.chain_bit = pin_sync[sar_conv_pkg::PIN_CHAIN];
  assign sh.div = serial_clock_divider_i;
  assign sh.word = result;

  sar_serial_shifter u_shifter (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sh(sh)
  );

  assign sclk_o = sh.sclk;
  assign sync_o = sh.sync;
  assign serial_result_out_o = sh.sdo;

  // Cycles since busy rose, for the checks below
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      busy_len <= '0;
    else if (!busy_o)
      busy_len <= '0;
    else
      busy_len <= busy_len + 1'b1;
  end

  property p_busy_bound;
    @(posedge clk_i) disable iff (!arst_n_i) busy_o && !rac |-> busy_len < conv_cyc;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy exceeded conversion limit");
  property p_data_in_time;
    @(posedge clk_i) disable iff (!arst_n_i) state == ST_RESULT && is_par |-> busy_len == conv_cyc - 1'b1;
  endproperty
  a_data_in_time: assert property (p_data_in_time) else $error("parallel result late");
  property p_data_before_busy_low;
    @(posedge clk_i) disable iff (!arst_n_i) $fell(busy_o) && !rac |-> $past(state) == ST_RESULT;
  endproperty
  a_data_before_busy_low: assert property (p_data_before_busy_low) else $error("busy fell without valid data");
  property p_rdc_frame;
    @(posedge clk_i) disable iff (!arst_n_i) start_edge && state == ST_IDLE && rdc |-> ##[2:7] sh.sync;
  endproperty
  a_rdc_frame: assert property (p_rdc_frame) else $error("read-during-convert frame not started");
  property p_rac_frame;
    @(posedge clk_i) disable iff (!arst_n_i) $rose(sh.sync) && rac |-> busy_o && busy_len > conv_cyc;
  endproperty
  a_rac_frame: assert property (p_rac_frame) else $error("read-after-convert frame before conversion end");
  property p_busy_after_sync;
    @(posedge clk_i) disable iff (!arst_n_i) $fell(sh.sync) && rac |-> busy_o ##1 !busy_o;
  endproperty
  a_busy_after_sync: assert property (p_busy_after_sync) else $error("busy not released after frame");
  property p_sclk_float;
    @(posedge clk_i) disable iff (!arst_n_i) $rose(pin_sync[sar_conv_pkg::PIN_CS]) |=> !sclk_oe_o;
  endproperty
  a_sclk_float: assert property (p_sclk_float) else $error("serial clock still driven");
  property p_sclk_drive;
    @(posedge clk_i) disable iff (!arst_n_i) $fell(pin_sync[sar_conv_pkg::PIN_CS]) && is_master |=> sclk_oe_o;
  endproperty
  a_sclk_drive: assert property (p_sclk_drive) else $error("serial clock not driven");
  c_parallel_conv: cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(busy_o) && is_par);
  c_rac_frame: cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(sh.sync) && rac);
  c_rdc_frame: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(sh.sync) && rdc);
  c_byte_swap: cover property (@(posedge clk_i) disable iff (!arst_n_i) state == ST_RESULT && swap_bytes);
endmodule : sar_conv_ctrl
`default_nettype wire

// [src/sar_serial_shifter.sv]
// Serial result shifter: master frames with internal clock, or slave shifting.
// Assumes start and loads come from the sequencer on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sar_serial_shifter (
  input wire logic clk_i,
  input wire logic arst_n_i,
  sar_shift_if.shifter sh
);
  typedef enum logic [1:0] {SH_IDLE = 2'h0, SH_LEAD = 2'h1, SH_RUN = 2'h3, SH_TRAIL = 2'h2} shift_state_t;
  localparam int CW = sar_conv_pkg::CNT_W;
  shift_state_t st;
  logic [CW-1:0] cnt;
  logic [5:0] half_edges;
  logic [15:0] shreg;
  logic [4:0] frame_rises;

  wire [CW-1:0] lead_cyc = sar_conv_pkg::cyc_min(sar_conv_pkg::FIRST_EDGE_NS[sh.div]);
  wire [CW-1:0] half_cyc = sar_conv_pkg::cyc_min(sar_conv_pkg::SCLK_MIN_NS[sh.div] / 2);
  wire [CW-1:0] trail_cyc = sar_conv_pkg::cyc_min(sar_conv_pkg::TRAIL_NS[sh.div]);
  wire last_half = (half_edges == 6'(sar_conv_pkg::SERIAL_HALF_EDGES - 1));

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st <= SH_IDLE;
      cnt <= '0;
      half_edges <= '0;
      shreg <= '0;
      sh.sclk <= 1'b0;
      sh.sync <= 1'b0;
      sh.done <= 1'b0;
    end
    else
    begin
      sh.done <= 1'b0;
      case (st)
        SH_IDLE:
        begin
          cnt <= '0;
          half_edges <= '0;
          if (sh.start)
          begin
            shreg <= sh.word;
            sh.sync <= 1'b1;
            st <= SH_LEAD;
          end
          else if (sh.slave_load)
            shreg <= sh.word;
          else if (sh.slave_edge)
            shreg <= {shreg[14:0], sh.chain_bit};
        end
        SH_LEAD:
          if (cnt == lead_cyc - 1'b1)
          begin
            cnt <= '0;
            st <= SH_RUN;
          end
          else
            cnt <= cnt + 1'b1;
        SH_RUN:
          if (cnt == half_cyc - 1'b1)
          begin
            cnt <= '0;
            sh.sclk <= ~sh.sclk;
            half_edges <= half_edges + 1'b1;
            if (sh.sclk)
              shreg <= {shreg[14:0], 1'b0};
            if (last_half)
              st <= SH_TRAIL;
          end
          else
            cnt <= cnt + 1'b1;
        SH_TRAIL:
          if (cnt == trail_cyc - 1'b1)
          begin
            sh.sync <= 1'b0;
            sh.done <= 1'b1;
            st <= SH_IDLE;
          end
          else
            cnt <= cnt + 1'b1;
        default:
          st <= SH_IDLE;
      endcase
    end
  end

  assign sh.sdo = shreg[15];

  // Rising serial edges seen in the current frame
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      frame_rises <= '0;
    else if (!sh.sync)
      frame_rises <= '0;
    else if (!sh.sclk && st == SH_RUN && cnt == half_cyc - 1'b1)
      frame_rises <= frame_rises + 1'b1;
  end

  property p_sixteen_clocks;
    @(posedge clk_i) disable iff (!arst_n_i) $fell(sh.sync) |-> $past(frame_rises) == 5'h10;
  endproperty
  a_sixteen_clocks: assert property (p_sixteen_clocks) else $error("frame did not carry 16 clocks");
  property p_first_edge_delay;
    @(posedge clk_i) disable iff (!arst_n_i) $rose(sh.sync) |-> !sh.sclk ##1 !sh.sclk;
  endproperty
  a_first_edge_delay: assert property (p_first_edge_delay) else $error("serial clock too soon after frame");
  property p_trail_delay;
    @(posedge clk_i) disable iff (!arst_n_i) $fell(sh.sync) |-> $past(sh.sclk) == 1'b0 && !sh.sclk;
  endproperty
  a_trail_delay: assert property (p_trail_delay) else $error("frame marker fell too soon");
  property p_clock_high_time;
    @(posedge clk_i) disable iff (!arst_n_i) $rose(sh.sclk) |-> sh.sync ##1 $fell(sh.sclk) && sh.sync;
  endproperty
  a_clock_high_time: assert property (p_clock_high_time) else $error("serial clock high time wrong");
  property p_slave_update;
    @(posedge clk_i) disable iff (!arst_n_i)
      st == SH_IDLE && !sh.start && !sh.slave_load && sh.slave_edge |=> sh.sdo == $past(shreg[14]);
  endproperty
  a_slave_update: assert property (p_slave_update) else $error("slave output not updated");
  c_frame_done: cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(sh.sync));
endmodule : sar_serial_shifter
`default_nettype wire

// [verif/sar_conversion_serial_timing_test.sv]
// Testbench for the conversion sequencer: parallel rows, master frames, chip select, slave shift.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_serial_timing_test;
  typedef struct packed {logic [1:0] tm; logic [1:0] pm; logic sw; logic [15:0] smp;} row_t;
  localparam row_t ROWS [7] = '{'{2'h0, 2'h0, 1'h0, 16'h1234}, '{2'h1, 2'h0, 1'h0, 16'hFEDC},
                                '{2'h2, 2'h1, 1'h0, 16'hA5C3}, '{2'h0, 2'h1, 1'h1, 16'h8001},
                                '{2'h1, 2'h1, 1'h1, 16'h7F3E}, '{2'h3, 2'h0, 1'h0, 16'h0F0F},
                                '{2'h2, 2'h0, 1'h1, 16'h4C21}};
  localparam int CONV_CYC [4] = '{7, 10, 12, 12};
  localparam int RDC_CYC [4] = '{2, 3, 6, 6};
  localparam int TRAIL_CYC [4] = '{1, 1, 2, 3};
  localparam logic [15:0] SMP [4] = '{16'hC35A, 16'h9E01, 16'h6B7D, 16'h8421};
  localparam logic [15:0] SLV = 16'hB62D;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic start_req = 1'h0;
  logic edge_req = 1'h0;
  logic cs_n = 1'h0;
  logic [1:0] tm = 2'h0;
  logic [1:0] pm = 2'h0;
  logic rac = 1'h0;
  logic [1:0] div = 2'h0;
  logic sw = 1'h0;
  logic chain = 1'h1;
  logic [15:0] smp = 16'h0000;
  logic conv_n;
  logic ext_sclk;
  logic busy_o;
  logic [15:0] pdata;
  logic sync_o;
  logic sync_oe;
  logic sclk_o;
  logic sclk_oe;
  logic sdo;
  logic sdo_oe;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int b_first, b_last, b_cnt, s_first, s_last, n_rise, n_hi;
  logic [15:0] word;
  logic [15:0] dat;

  sar_host_model host (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_req_i(start_req), .edge_req_i(edge_req),
    .throughput_mode_i(tm), .conversion_start_n_o(conv_n), .ext_sclk_o(ext_sclk));

  sar_conv_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .conversion_start_n_i(conv_n), .cs_n_i(cs_n),
    .ext_sclk_i(ext_sclk), .chain_serial_in_i(chain), .throughput_mode_i(tm), .port_mode_i(pm),
    .read_after_i(rac), .serial_clock_divider_i(div), .byte_order_select_i(sw), .sample_i(smp),
    .busy_o(busy_o), .parallel_data_o(pdata), .sync_o(sync_o), .sync_oe_o(sync_oe), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe), .serial_result_out_o(sdo), .serial_result_out_oe_o(sdo_oe));

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Whole run needs about 1700 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk_n(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  // One conversion, then an 80-cycle watch of busy, frame, clock and data
  task automatic run_conv();
    logic prev;
    prev = 1'h0;
    @(posedge clk_i);
    start_req <= 1'h1;
    @(posedge clk_i);
    start_req <= 1'h0;
    b_first = -1;
    s_first = -1;
    b_last = 0;
    s_last = 0;
    b_cnt = 0;
    n_rise = 0;
    n_hi = 0;
    for (int i = 0; i < 80; i++)
    begin
      @(negedge clk_i);
      if (busy_o === 1'h1)
      begin
        if (b_first < 0)
          b_first = i;
        b_last = i;
        b_cnt++;
        dat = pdata;
      end
      if (sync_o === 1'h1)
      begin
        if (s_first < 0)
          s_first = i;
        s_last = i;
      end
      if (sclk_o === 1'h1)
        n_hi++;
      if (sclk_o === 1'h1 && prev === 1'h0)
      begin
        n_rise++;
        word = {word[14:0], sdo};
      end
      prev = sclk_o;
    end
  endtask : run_conv

  initial
  begin
    repeat (20) @(posedge clk_i);
    chk16({busy_o, sync_o, sclk_o, sdo, sync_oe, sclk_oe, sdo_oe, 9'h000}, 16'h0000);
    arst_n_i <= 1'h1;
    foreach (ROWS[r])
    begin
      @(posedge clk_i);
      tm <= ROWS[r].tm;
      pm <= ROWS[r].pm;
      sw <= ROWS[r].sw;
      smp <= ROWS[r].smp;
      run_conv();
      chk_n(b_cnt, CONV_CYC[ROWS[r].tm]);
      chk16(dat, (ROWS[r].pm == sar_conv_pkg::PORT_PAR8 && ROWS[r].sw) ?
        {ROWS[r].smp[7:0], ROWS[r].smp[15:8]} : ROWS[r].smp);
    end
    // Read-during-convert frames send the previous result
    for (int d = 0; d < 4; d++)
    begin
      @(posedge clk_i);
      pm <= sar_conv_pkg::PORT_MASTER;
      div <= 2'(d);
      tm <= 2'(d % 3);
      smp <= SMP[d];
      run_conv();
      chk_n(s_first - b_first, RDC_CYC[d % 3]);
      chk_n(n_rise, 16);
      chk_n(n_hi, 16);
      chk_n(s_last - s_first + 1, 33 + TRAIL_CYC[d]);
      chk16(word, (d > 0) ? SMP[d - 1] : ROWS[6].smp);
    end
    for (int d = 0; d < 4; d++)
    begin
      @(posedge clk_i);
      rac <= 1'h1;
      div <= 2'(d);
      tm <= 2'((d + 1) % 3);
      smp <= SMP[d];
      run_conv();
      chk_n(s_first - b_first, CONV_CYC[(d + 1) % 3] + 1);
      chk_n(b_last - s_last, 1);
      chk_n(b_cnt, CONV_CYC[(d + 1) % 3] + 35 + TRAIL_CYC[d]);
      chk_n(n_rise, 16);
      chk16(word, SMP[d]);
      chk_n(s_last - s_first + 1, 33 + TRAIL_CYC[d]);
    end
    @(posedge clk_i);
    cs_n <= 1'h1;
    repeat (5) @(negedge clk_i);
    chk16({13'h0000, sync_oe, sclk_oe, sdo_oe}, 16'h0000);
    @(posedge clk_i);
    cs_n <= 1'h0;
    repeat (5) @(negedge clk_i);
    chk16({13'h0000, sync_oe, sclk_oe, sdo_oe}, 16'h0007);
    // Slave shift: sixteen result bits, then the chain input appears
    @(posedge clk_i);
    pm <= sar_conv_pkg::PORT_SLAVE;
    smp <= SLV;
    run_conv();
    for (int k = 0; k < 18; k++)
    begin
      chk16({15'h0000, sdo}, {15'h0000, (k < 16) ? SLV[15 - k] : (k == 17)});
      @(posedge clk_i);
      edge_req <= 1'h1;
      chain <= (k != 0);
      @(posedge clk_i);
      edge_req <= 1'h0;
      repeat (10) @(negedge clk_i);
    end
    // Reset in mid-conversion drops busy; the next conversion runs in full
    @(posedge clk_i);
    start_req <= 1'h1;
    @(posedge clk_i);
    start_req <= 1'h0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'h0;
    repeat (2) @(negedge clk_i);
    chk16({busy_o, sync_o, sclk_o, sdo, sync_oe, sclk_oe, sdo_oe, 9'h000}, 16'h0000);
    @(posedge clk_i);
    arst_n_i <= 1'h1;
    run_conv();
    chk_n(b_cnt, CONV_CYC[1]);
    chk16(dat, SLV);
    give_verdict();
  end
endmodule : sar_conversion_serial_timing_test
`default_nettype wire

// [verif/sar_host_model.sv]
// Host model: paces conversion starts and clocks the slave serial port.
// Assumes requests arrive as one-cycle pulses on the system clock.
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_req_i,
  input wire logic edge_req_i,
  input wire logic [1:0] throughput_mode_i,
  output logic conversion_start_n_o,
  output logic ext_sclk_o
);
  logic pend;
  logic [4:0] gap;
  logic [3:0] lo_cnt;
  logic [3:0] ck_cnt;
  wire logic [4:0] min_gap;
  wire logic fire;

  // Start spacing in cycles per throughput mode
  assign min_gap = (throughput_mode_i == 2'h0) ? 5'h0A : (throughput_mode_i == 2'h1) ? 5'h0D : 5'h0F;
  // Requests wait out the mode's start spacing and the previous low pulse, so restarts never come too early
  assign fire = pend && (gap >= min_gap) && (lo_cnt == 4'h0);
  assign conversion_start_n_o = (lo_cnt == 4'h0);
  // External clock stands low outside requested edges
  assign ext_sclk_o = (ck_cnt > 4'h4);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pend <= 1'h0;
      gap <= 5'h1F;
      lo_cnt <= 4'h0;
      ck_cnt <= 4'h0;
    end
    else
    begin
      if (fire)
      begin
        pend <= 1'h0;
        gap <= 5'h00;
        lo_cnt <= 4'h3;
      end
      else
      begin
        if (gap != 5'h1F)
          gap <= gap + 5'h01;
        if (lo_cnt != 4'h0)
          lo_cnt <= lo_cnt - 4'h1;
      end
      if (start_req_i)
        pend <= 1'h1;
      if (edge_req_i)
        ck_cnt <= 4'h8;
      else if (ck_cnt != 4'h0)
        ck_cnt <= ck_cnt - 4'h1;
    end
  end
endmodule : sar_host_model
`default_nettype wire
